// file: hdl/fpa_unit.sv
// fpa_unit.sv: floating point add, subtract, multiply and divide datapath
// with operand fetch, equalization, rounding, normalization and faults.
// assumes: instruction control, core storage and the sense path all run
// on CLK_I; storage answers a held read with a one-cycle MEM_ACK_I.
`timescale 1ns/100ps
`default_nettype none
`include "fpa_cfg.svh"

module fpa_unit #(
    parameter int ADDR_W = 18
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic START_I,
    input wire logic [1:0] OP_I,
    input wire logic [47:0] ACC_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [ADDR_W-1:0] INDEX_I,
    input wire logic INDIRECT_I,
    input wire logic [23:0] MEM_RDATA_I,
    input wire logic MEM_ACK_I,
    input wire logic SENSE_I,
    input wire logic [1:0] SENSE_SEL_I,
    output logic [ADDR_W-1:0] MEM_ADDR_O,
    output logic MEM_RD_O,
    output logic [47:0] RESULT_O,
    output logic [47:0] EXT_O,
    output logic CMP_GT_O,
    output logic BUSY_O,
    output logic DONE_O,
    output logic [2:0] FAULT_O,
    output logic SENSE_O,
    output logic FAULT_IRQ_O
);
    fpa_pkg::fpa_state_t state_q;
    fpa_pkg::fpa_op_t op_q;
    fpa_pkg::fpa_rnd_t rnd_q;
    logic [47:0] acc_q;
    logic [47:0] mem_q;
    logic [ADDR_W-1:0] ea_q;
    logic [37:0] res_q;
    logic [37:0] mb_q;
    logic [35:0] ext_q;
    logic signed [12:0] exp_q;
    logic sr_q;
    logic sb_q;
    logic shift_a_q;
    logic [5:0] cnt_q;
    logic [2:0] flt_q;
    logic [2:0] flt_set;
    logic [2:0] flt_clr;
    logic [2:0] flt_d;

    fpa_opnd_if ua ();
    fpa_opnd_if ub ();

    fpa_unpack u_unpack_acc (
        .op(ua)
    );
    fpa_unpack u_unpack_mem (
        .op(ub)
    );

    assign ua.word = acc_q;
    assign ub.word = mem_q;

    // operand selection and equalization figures
    logic sb_eff;
    logic a_smaller;
    logic signed [12:0] exp_diff;
    logic [5:0] shift_cnt;
    assign sb_eff = ub.sgn ^ (op_q == fpa_pkg::FPA_OP_SUB);
    assign a_smaller = ua.exp < ub.exp;
    assign exp_diff = a_smaller ? ub.exp - ua.exp : ua.exp - ub.exp;
    assign shift_cnt = (exp_diff[12:6] != 7'h00) ? `FPA_MAX_SHIFT
                                                 : exp_diff[5:0];

    // add and subtract on magnitudes, larger minus smaller
    logic same_sign;
    logic a_ge_b;
    logic [37:0] sum_mag;
    logic sum_sign;
    logic shifted_sign;
    assign same_sign = (sr_q == sb_q);
    assign a_ge_b = res_q >= mb_q;
    assign sum_mag = same_sign ? res_q + mb_q
                   : (a_ge_b ? res_q - mb_q : mb_q - res_q);
    assign sum_sign = (same_sign || a_ge_b) ? sr_q : sb_q;
    assign shifted_sign = shift_a_q ? sr_q : sb_q;

    // multiply and divide on coefficient magnitudes
    logic [71:0] prod;
    logic [71:0] dividend;
    logic [71:0] divisor;
    logic [71:0] quot;
    logic [71:0] resid;
    logic div_half;
    assign prod = {36'h0, res_q[35:0]} * {36'h0, mb_q[35:0]};
    assign dividend = {res_q[35:0], 36'h0};
    // a bad divisor is swapped for one so no unknown reaches the residue
    assign divisor = {36'h0, ub.norm_ok ? mb_q[35:0] : 36'h1};
    assign quot = dividend / divisor;
    assign resid = dividend % divisor;
    // residue at least half the divisor
    assign div_half = {resid[70:0], 1'b0} >= divisor;

    // packing of the normalized result
    logic [12:0] exp_biased;
    logic [47:0] packed_pos;
    logic exp_ovf;
    logic exp_unf;
    // bias by sign of true exponent
    // zero exponent always takes the plus bias
    assign exp_biased = (exp_q >= 13'sh0000) ? exp_q + `FPA_BIAS_POS
                                             : exp_q + `FPA_BIAS_NEG;
    assign packed_pos = {1'b0, exp_biased[10:0], res_q[35:0]};
    // usable range is plus or minus 1023
    assign exp_ovf = exp_q > $signed(`FPA_EXP_MAX);
    assign exp_unf = exp_q < $signed(`FPA_EXP_MIN);

    // main sequencer: fetch, equalize, operate, round, normalize, pack
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_q <= fpa_pkg::FPA_ST_IDLE;
            op_q <= fpa_pkg::FPA_OP_ADD;
            rnd_q <= fpa_pkg::FPA_RND_NONE;
            acc_q <= 48'h0;
            mem_q <= 48'h0;
            ea_q <= '0;
            res_q <= 38'h0;
            mb_q <= 38'h0;
            ext_q <= 36'h0;
            exp_q <= 13'sh0000;
            sr_q <= 1'b0;
            sb_q <= 1'b0;
            shift_a_q <= 1'b0;
            cnt_q <= 6'h00;
            MEM_ADDR_O <= '0;
            MEM_RD_O <= 1'b0;
            RESULT_O <= 48'h0;
            EXT_O <= 48'h0;
            CMP_GT_O <= 1'b0;
            BUSY_O <= 1'b0;
            DONE_O <= 1'b0;
        end else begin
            DONE_O <= 1'b0;
            case (state_q)
                fpa_pkg::FPA_ST_IDLE: begin
                    if (START_I) begin
                        op_q <= fpa_pkg::fpa_op_t'(OP_I);
                        acc_q <= ACC_I;
                        BUSY_O <= 1'b1;
                        ea_q <= ADDR_I + INDEX_I;
                        MEM_ADDR_O <= ADDR_I + INDEX_I;
                        MEM_RD_O <= 1'b1;
                        state_q <= INDIRECT_I ? fpa_pkg::FPA_ST_IND
                                              : fpa_pkg::FPA_ST_RD_HI;
                    end
                end
                fpa_pkg::FPA_ST_IND: begin
                    if (MEM_ACK_I) begin
                        ea_q <= MEM_RDATA_I[ADDR_W-1:0];
                        MEM_ADDR_O <= MEM_RDATA_I[ADDR_W-1:0];
                        state_q <= fpa_pkg::FPA_ST_RD_HI;
                    end
                end
                fpa_pkg::FPA_ST_RD_HI: begin
                    // words M and M+1 form one operand
                    if (MEM_ACK_I) begin
                        mem_q[47:24] <= MEM_RDATA_I;
                        MEM_ADDR_O <= ea_q + ADDR_W'(1);
                        state_q <= fpa_pkg::FPA_ST_RD_LO;
                    end
                end
                fpa_pkg::FPA_ST_RD_LO: begin
                    if (MEM_ACK_I) begin
                        mem_q[23:0] <= MEM_RDATA_I;
                        MEM_RD_O <= 1'b0;
                        state_q <= fpa_pkg::FPA_ST_LOAD;
                    end
                end
                fpa_pkg::FPA_ST_LOAD: begin
                    res_q <= {2'b00, ua.coef};
                    mb_q <= {2'b00, ub.coef};
                    sr_q <= ua.sgn;
                    ext_q <= 36'h0;
                    if (op_q == fpa_pkg::FPA_OP_MUL ||
                        op_q == fpa_pkg::FPA_OP_DIV) begin
                        sb_q <= ub.sgn;
                        cnt_q <= 6'h00;
                        exp_q <= (op_q == fpa_pkg::FPA_OP_MUL)
                               ? ua.exp + ub.exp : ua.exp - ub.exp;
                    end else begin
                        sb_q <= sb_eff;
                        shift_a_q <= a_smaller;
                        cnt_q <= shift_cnt;
                        exp_q <= a_smaller ? ub.exp : ua.exp;
                    end
                    state_q <= fpa_pkg::FPA_ST_ALIGN;
                end
                fpa_pkg::FPA_ST_ALIGN: begin
                    // one position per clock through the combined chain
                    if (cnt_q == 6'h00) begin
                        state_q <= fpa_pkg::FPA_ST_ARITH;
                    end else if (shift_a_q) begin
                        {res_q[35:0], ext_q} <= {1'b0, res_q[35:0], ext_q[35:1]};
                        cnt_q <= cnt_q - 6'h01;
                    end else begin
                        {mb_q[35:0], ext_q} <= {1'b0, mb_q[35:0], ext_q[35:1]};
                        cnt_q <= cnt_q - 6'h01;
                    end
                end
                fpa_pkg::FPA_ST_ARITH: begin
                    state_q <= fpa_pkg::FPA_ST_ROUND;
                    case (op_q)
                        fpa_pkg::FPA_OP_MUL: begin
                            res_q <= {2'b00, prod[71:36]};
                            ext_q <= prod[35:0];
                            sr_q <= sr_q ^ sb_q;
                            rnd_q <= prod[35] ? fpa_pkg::FPA_RND_PLUS
                                              : fpa_pkg::FPA_RND_NONE;
                        end
                        fpa_pkg::FPA_OP_DIV: begin
                            res_q <= quot[37:0];
                            ext_q <= resid[35:0];
                            sr_q <= sr_q ^ sb_q;
                            rnd_q <= div_half ? fpa_pkg::FPA_RND_PLUS
                                              : fpa_pkg::FPA_RND_NONE;
                            if (!ub.norm_ok) begin
                                state_q <= fpa_pkg::FPA_ST_PACK;
                            end
                        end
                        default: begin
                            res_q <= sum_mag;
                            sr_q <= sum_sign;
                            // round only on a lost half bit
                            // downward when the shifted side is opposite
                            if (!ext_q[35]) begin
                                rnd_q <= fpa_pkg::FPA_RND_NONE;
                            end else if (shifted_sign == sum_sign) begin
                                rnd_q <= fpa_pkg::FPA_RND_PLUS;
                            end else begin
                                rnd_q <= fpa_pkg::FPA_RND_MINUS;
                            end
                        end
                    endcase
                end
                fpa_pkg::FPA_ST_ROUND: begin
                    // one at the low bit, exponent untouched
                    if (rnd_q == fpa_pkg::FPA_RND_PLUS) begin
                        res_q <= res_q + 38'h1;
                    end else if (rnd_q == fpa_pkg::FPA_RND_MINUS) begin
                        res_q <= res_q - 38'h1;
                    end
                    state_q <= fpa_pkg::FPA_ST_NORM;
                end
                fpa_pkg::FPA_ST_NORM: begin
                    // shift coefficient only, never the residue
                    if (res_q[37:36] != 2'b00) begin
                        res_q <= {1'b0, res_q[37:1]};
                        exp_q <= exp_q + 13'sh0001;
                    end else if (!res_q[35] && res_q != 38'h0) begin
                        res_q <= {res_q[36:0], 1'b0};
                        exp_q <= exp_q - 13'sh0001;
                    end else begin
                        state_q <= fpa_pkg::FPA_ST_PACK;
                    end
                end
                fpa_pkg::FPA_ST_PACK: begin
                    // faulted operations leave the accumulator as it was
                    if (|flt_set) begin
                        RESULT_O <= acc_q;
                    end else if (res_q == 38'h0) begin
                        RESULT_O <= 48'h0;
                    end else begin
                        RESULT_O <= sr_q ? ~packed_pos : packed_pos;
                    end
                    EXT_O <= {12'h000, ext_q};
                    // bias lets plain signed word compare work
                    CMP_GT_O <= $signed(acc_q) > $signed(mem_q);
                    BUSY_O <= 1'b0;
                    DONE_O <= 1'b1;
                    state_q <= fpa_pkg::FPA_ST_IDLE;
                end
                default: begin
                    state_q <= fpa_pkg::FPA_ST_IDLE;
                end
            endcase
        end
    end

    // fault detection happens at pack time, the only place a result exists
    logic in_pack;
    logic div_op;
    logic nonzero;
    assign in_pack = (state_q == fpa_pkg::FPA_ST_PACK);
    assign div_op = (op_q == fpa_pkg::FPA_OP_DIV);
    assign nonzero = (res_q != 38'h0);
    assign flt_set[`FPA_FLT_OVF] = in_pack && nonzero && exp_ovf
                                   && !(div_op && !ub.norm_ok);
    assign flt_set[`FPA_FLT_UNF] = in_pack && nonzero && exp_unf
                                   && !(div_op && !ub.norm_ok);
    assign flt_set[`FPA_FLT_DIV] = in_pack && div_op && !ub.norm_ok;

    // sensing one flag clears that flag only
    assign flt_clr[0] = SENSE_I && (SENSE_SEL_I == 2'h0);
    assign flt_clr[1] = SENSE_I && (SENSE_SEL_I == 2'h1);
    assign flt_clr[2] = SENSE_I && (SENSE_SEL_I == 2'h2);
    // a fault raised in the sensing cycle survives the clear
    assign flt_d = flt_set | (flt_q & ~flt_clr);

    // sticky flags, sense answer and interrupt request
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            flt_q <= 3'h0;
            FAULT_O <= 3'h0;
            SENSE_O <= 1'b0;
            FAULT_IRQ_O <= 1'b0;
        end else begin
            flt_q <= flt_d;
            FAULT_O <= flt_d;
            // sensed value is the flag before clearing
            SENSE_O <= SENSE_I && (SENSE_SEL_I != 2'h3)
                       && (flt_q[SENSE_SEL_I] || flt_set[SENSE_SEL_I]);
            // any pending flag asks for an interrupt
            FAULT_IRQ_O <= |flt_d;
        end
    end

endmodule

`default_nettype wire

// file: hdl/fpa_cfg.svh
// fpa_cfg.svh: offsets, field positions, biases and limits of the
// floating point arithmetic unit.
// assumes: included by bare name from every file that needs the figures.
`ifndef FPA_CFG_SVH
`define FPA_CFG_SVH

// floating word layout
`define FPA_SIGN_BIT 47
`define FPA_EXP_MSB 46
`define FPA_EXP_LSB 36
`define FPA_COEF_MSB 35

// exponent biases and range, held as 13-bit two's complement
`define FPA_BIAS_POS 13'h0400
`define FPA_BIAS_NEG 13'h03FF
`define FPA_EXP_MAX 13'h03FF
`define FPA_EXP_MIN 13'h1C01

// alignment shifter limit (63 positions)
`define FPA_MAX_SHIFT 6'h3F

// fault flag positions
`define FPA_FLT_OVF 0
`define FPA_FLT_UNF 1
`define FPA_FLT_DIV 2

`endif

// file: hdl/fpa_pkg.sv
// fpa_pkg.sv: types shared by the floating point arithmetic unit.
// assumes: compiled before every file that names these types.
package fpa_pkg;

    typedef enum logic [1:0] {
        FPA_OP_ADD,
        FPA_OP_SUB,
        FPA_OP_MUL,
        FPA_OP_DIV
    } fpa_op_t;

    typedef enum logic [3:0] {
        FPA_ST_IDLE,
        FPA_ST_IND,
        FPA_ST_RD_HI,
        FPA_ST_RD_LO,
        FPA_ST_LOAD,
        FPA_ST_ALIGN,
        FPA_ST_ARITH,
        FPA_ST_ROUND,
        FPA_ST_NORM,
        FPA_ST_PACK
    } fpa_state_t;

    typedef enum logic [1:0] {
        FPA_RND_NONE,
        FPA_RND_PLUS,
        FPA_RND_MINUS
    } fpa_rnd_t;

endpackage

// file: hdl/fpa_opnd_if.sv
// fpa_opnd_if.sv: one floating operand, packed word and its unpacked fields.
// assumes: the unpacker drives the fields, the datapath drives the word.
`timescale 1ns/100ps
`default_nettype none

interface fpa_opnd_if;
    logic [47:0] word;
    logic sgn;
    logic signed [12:0] exp;
    logic [35:0] coef;
    logic norm_ok;

    modport unpack (input word, output sgn, exp, coef, norm_ok);
    modport user (output word, input sgn, exp, coef, norm_ok);
endinterface

`default_nettype wire

// file: hdl/fpa_unpack.sv
// fpa_unpack.sv: splits a floating word into sign, true exponent and
// coefficient magnitude.
// assumes: purely combinational, fed from registers of the caller.
`timescale 1ns/100ps
`default_nettype none
`include "fpa_cfg.svh"

module fpa_unpack (
    fpa_opnd_if.unpack op
);
    logic [47:0] mag;
    logic [12:0] biased;

    // a negative word is the complement of the whole positive word
    assign mag = op.word[`FPA_SIGN_BIT] ? ~op.word : op.word;
    assign biased = {2'b00, mag[`FPA_EXP_MSB:`FPA_EXP_LSB]};
    assign op.sgn = op.word[`FPA_SIGN_BIT];
    // bias removal: 2000 octal upward, 1777 octal below it
    assign op.exp = (biased >= `FPA_BIAS_POS) ? biased - `FPA_BIAS_POS
                                              : biased - `FPA_BIAS_NEG;
    assign op.coef = mag[`FPA_COEF_MSB:0];
    // a floating divisor must have its top coefficient bit set
    assign op.norm_ok = mag[`FPA_COEF_MSB];
endmodule

`default_nettype wire

// file: testbench/fpa_unit_asserts.sv
// fpa_unit_asserts.sv: port-level properties of the floating point unit.
// assumes: bound to fpa_unit, sees its ports only, one clock domain.
`timescale 1ns/100ps
`default_nettype none

module fpa_unit_asserts #(
    parameter int ADDR_W = 18
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic START_I,
    input wire logic SENSE_I,
    input wire logic [1:0] SENSE_SEL_I,
    input wire logic MEM_ACK_I,
    input wire logic [ADDR_W-1:0] MEM_ADDR_O,
    input wire logic MEM_RD_O,
    input wire logic [47:0] RESULT_O,
    input wire logic BUSY_O,
    input wire logic DONE_O,
    input wire logic [2:0] FAULT_O,
    input wire logic SENSE_O,
    input wire logic FAULT_IRQ_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    // a request in idle must raise busy at once
    property p_start_busy;
        START_I && !BUSY_O |=> BUSY_O;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("start in idle not taken");

    // a bad divisor with zero-wait storage ends soonest; worst case is
    // about 110 cycles plus storage waits
    property p_done_bound;
        $rose(BUSY_O) |-> ##[5:400] DONE_O;
    endproperty
    a_done_bound: assert property (p_done_bound)
        else $error("operation never completed");

    property p_done_pulse;
        DONE_O |-> $past(BUSY_O) && !BUSY_O ##1 !DONE_O;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("completion pulse malformed");

    property p_result_hold;
        !DONE_O |-> $stable(RESULT_O);
    endproperty
    a_result_hold: assert property (p_result_hold)
        else $error("result moved without completion");

    // a pending read holds its address until answered
    property p_rd_hold;
        MEM_RD_O && !MEM_ACK_I |=> MEM_RD_O && $stable(MEM_ADDR_O);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read request dropped or address moved");

    property p_rd_busy;
        MEM_RD_O |-> BUSY_O;
    endproperty
    a_rd_busy: assert property (p_rd_busy)
        else $error("storage read outside an operation");

    property p_sense_none;
        SENSE_I && SENSE_SEL_I == 2'h3 |=> !SENSE_O;
    endproperty
    a_sense_none: assert property (p_sense_none)
        else $error("empty sense answered high");

    property p_sense_val;
        SENSE_I && SENSE_SEL_I != 2'h3 |=>
            SENSE_O == $past(FAULT_O[SENSE_SEL_I]);
    endproperty
    a_sense_val: assert property (p_sense_val)
        else $error("sensed value differs from flag");

    // busy low means no completion can land on the next edge
    property p_sense_clr;
        SENSE_I && SENSE_SEL_I == 2'h2 && !BUSY_O |=> !FAULT_O[2];
    endproperty
    a_sense_clr: assert property (p_sense_clr)
        else $error("sensed flag not cleared");

    property p_irq;
        FAULT_IRQ_O == (|FAULT_O);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt request differs from flags");

    property p_sticky;
        !SENSE_I |=> ($past(FAULT_O) & ~FAULT_O) == 3'h0;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag cleared without sense");

    property p_fault_set;
        (FAULT_O & ~$past(FAULT_O)) != 3'h0 |-> DONE_O;
    endproperty
    a_fault_set: assert property (p_fault_set)
        else $error("flag set outside completion");
endmodule

bind fpa_unit fpa_unit_asserts #(.ADDR_W(ADDR_W)) u_fpa_chk (
    .CLK_I(CLK_I),
    .RSTN_I(RSTN_I),
    .START_I(START_I),
    .SENSE_I(SENSE_I),
    .SENSE_SEL_I(SENSE_SEL_I),
    .MEM_ACK_I(MEM_ACK_I),
    .MEM_ADDR_O(MEM_ADDR_O),
    .MEM_RD_O(MEM_RD_O),
    .RESULT_O(RESULT_O),
    .BUSY_O(BUSY_O),
    .DONE_O(DONE_O),
    .FAULT_O(FAULT_O),
    .SENSE_O(SENSE_O),
    .FAULT_IRQ_O(FAULT_IRQ_O)
);

`default_nettype wire

// file: testbench/fpa_mem_model.sv
// fpa_mem_model.sv: behavioural core storage answering the unit's reads.
// assumes: the bench loads words into mem directly, one read at a time.
`timescale 1ns/100ps
`default_nettype none

module fpa_mem_model #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic rd_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [3:0] wait_i,
    output logic ack_o,
    output logic [23:0] data_o
);
    logic [23:0] mem [2**ADDR_W];
    int cnt;

    // unloaded words are not floating values, so a stray address shows
    initial begin
        foreach (mem[i]) begin
            mem[i] = 24'h5A5A5A;
        end
        ack_o = 1'b0;
        data_o = 24'h000000;
        cnt = 0;
    end

    // consecutive word answers
    // answers from the address shown after the edge; idle data toggles
    always @(posedge clk_i) begin
        #1;
        if (rd_i && cnt >= int'(wait_i)) begin
            ack_o = 1'b1;
            data_o = mem[addr_i];
            cnt = 0;
        end else begin
            ack_o = 1'b0;
            data_o = ~data_o;
            cnt = rd_i ? cnt + 1 : 0;
        end
    end
endmodule

`default_nettype wire

// file: testbench/fpa_unit_tb_top.sv
// fpa_unit_tb_top.sv: self-checking bench for the floating point unit.
// assumes: storage model on the read port, bench acts as instruction control.
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end

module fpa_unit_tb_top;
    localparam int AW = 8;
    localparam logic [47:0] HALF = 48'h400800000000;
    localparam logic [47:0] FOUR = 48'h403800000000;
    logic clk, rst_n, start, ind, mack, sense, mrd, cmp_gt, busy, done;
    logic sensed, irq;
    logic [1:0] op, ssel;
    logic [47:0] acc, res, ext;
    logic [AW-1:0] addr, idx, maddr;
    logic [23:0] mdata;
    logic [2:0] fault;
    logic [3:0] mwait;
    int n_errors = 0;
    int checks_done = 0;

    fpa_unit #(.ADDR_W(AW)) dut (
        .CLK_I(clk), .RSTN_I(rst_n), .START_I(start), .OP_I(op),
        .ACC_I(acc), .ADDR_I(addr), .INDEX_I(idx), .INDIRECT_I(ind),
        .MEM_RDATA_I(mdata), .MEM_ACK_I(mack), .SENSE_I(sense),
        .SENSE_SEL_I(ssel), .MEM_ADDR_O(maddr), .MEM_RD_O(mrd),
        .RESULT_O(res), .EXT_O(ext), .CMP_GT_O(cmp_gt), .BUSY_O(busy),
        .DONE_O(done), .FAULT_O(fault), .SENSE_O(sensed), .FAULT_IRQ_O(irq)
    );

    fpa_mem_model #(.ADDR_W(AW)) mm (
        .clk_i(clk), .rd_i(mrd), .addr_i(maddr), .wait_i(mwait),
        .ack_o(mack), .data_o(mdata)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // poke sends a conflicting request while busy, which must be dropped
    task automatic run_op(input fpa_pkg::fpa_op_t o, input logic [47:0] a,
        input logic [AW-1:0] ad, input logic in, input logic poke,
        output int cyc);
        @(posedge clk);
        start <= 1'b1;
        op <= o;
        acc <= a;
        addr <= ad;
        idx <= 8'h02;
        ind <= in;
        @(posedge clk);
        start <= 1'b0;
        if (poke) begin
            @(posedge clk);
            start <= 1'b1;
            op <= fpa_pkg::FPA_OP_DIV;
            acc <= ~a;
            @(posedge clk);
            start <= 1'b0;
        end
        cyc = 0;
        while (done !== 1'b1 && cyc < 400) begin
            @(negedge clk);
            cyc++;
        end
        `CHK(done, 1'b1)
    endtask

    task automatic expect_res(input logic [47:0] r, input logic [2:0] f,
        input logic g);
        `CHK(res, r)
        `CHK(fault, f)
        `CHK(cmp_gt, g)
    endtask

    task automatic do_sense(input logic [1:0] s, input logic e,
        input logic [2:0] f);
        @(posedge clk);
        sense <= 1'b1;
        ssel <= s;
        @(posedge clk);
        sense <= 1'b0;
        @(negedge clk);
        `CHK(sensed, e)
        `CHK(fault, f)
        `CHK(irq, |f)
    endtask

    // equal exponents, zero-wait storage: fixed latency, carry normalized
    task automatic t_add();
        int c;
        mwait = 4'h0;
        run_op(fpa_pkg::FPA_OP_ADD, HALF, 8'h0E, 1'b0, 1'b0, c);
        `CHK(c, 10)
        expect_res(48'h401800000000, 3'h0, 1'b0);
        `CHK(ext, 48'h0)
        $display("test add done");
    endtask

    // accumulator has the smaller exponent; negative result, slow storage
    task automatic t_sub();
        int c;
        mwait = 4'h2;
        run_op(fpa_pkg::FPA_OP_SUB, HALF, 8'h10, 1'b0, 1'b1, c);
        expect_res(48'hBFD1FFFFFFFF, 3'h0, 1'b0);
        repeat (3) @(negedge clk);
        `CHK(busy, 1'b0)
        $display("test sub done");
    endtask

    // first lost bit set with like signs rounds up by one
    task automatic t_round();
        int c;
        mwait = 4'h1;
        run_op(fpa_pkg::FPA_OP_ADD, 48'h400800000004, 8'h10, 1'b0, 1'b0, c);
        expect_res(48'h403900000001, 3'h0, 1'b0);
        `CHK(ext, 48'h000800000000)
        $display("test round done");
    endtask

    // negative accumulator, memory operand through a pointer word, then an exact divide
    task automatic t_mul_div();
        int c;
        mwait = 4'h0;
        run_op(fpa_pkg::FPA_OP_MUL, ~FOUR, 8'h16, 1'b1, 1'b0, c);
        expect_res(48'hBFD7FFFFFFFF, 3'h0, 1'b0);
        run_op(fpa_pkg::FPA_OP_DIV, FOUR, 8'h0E, 1'b0, 1'b0, c);
        expect_res(48'h404800000000, 3'h0, 1'b1);
        $display("test mul div done");
    endtask

    // each fault keeps the accumulator, holds until sensed, then clears
    task automatic t_faults();
        int c;
        mwait = 4'h1;
        run_op(fpa_pkg::FPA_OP_DIV, HALF, 8'h12, 1'b0, 1'b0, c);
        expect_res(HALF, 3'h4, 1'b1);
        do_sense(2'h3, 1'b0, 3'h4);
        do_sense(2'h2, 1'b1, 3'h0);
        do_sense(2'h2, 1'b0, 3'h0);
        run_op(fpa_pkg::FPA_OP_MUL, 48'h7FF800000000, 8'h10, 1'b0, 1'b0, c);
        expect_res(48'h7FF800000000, 3'h1, 1'b1);
        do_sense(2'h1, 1'b0, 3'h1);
        do_sense(2'h0, 1'b1, 3'h0);
        run_op(fpa_pkg::FPA_OP_MUL, 48'h000800000000, 8'h0E, 1'b0, 1'b0, c);
        expect_res(48'h000800000000, 3'h2, 1'b0);
        do_sense(2'h1, 1'b1, 3'h0);
        $display("test faults done");
    endtask

    // watchdog: all tests finish within about 150 cycles
    initial begin
        repeat (6000) @(posedge clk);
        n_errors++;
        $display("watchdog expired");
        final_report();
    end

    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        op = 2'h0;
        acc = 48'h0;
        addr = 8'h00;
        idx = 8'h00;
        ind = 1'b0;
        sense = 1'b0;
        ssel = 2'h3;
        mwait = 4'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        mm.mem[8'h10] = 24'h400800;
        mm.mem[8'h11] = 24'h000000;
        mm.mem[8'h12] = 24'h403800;
        mm.mem[8'h13] = 24'h000000;
        mm.mem[8'h14] = 24'h000000;
        mm.mem[8'h15] = 24'h000000;
        mm.mem[8'h18] = 24'h000010;
        t_add();
        t_sub();
        t_round();
        t_mul_div();
        t_faults();
        final_report();
    end
endmodule

`default_nettype wire
